/* File: vlit_top.sv */
// vlan table, indirect access registers and packet classification top
// assumes all inputs come from logic on CLK_IN; dynamic table lives outside
`timescale 1ns/1ps
// Overview of operation
// - control write 0x1800 fetches dynamic entry 0 with valid-entry count
// - dynamic bits 63:48 word3, 47:32 word2, 31:16 word5, 15:0 word4
// - vlan table consulted only while control 2 bit 15 is set
// - entry bit 19 is valid, default one; only valid entries match
// - entry bits 18:16 are port membership, default 111, bit 18 port 3
// - entry bits 15:12 filter index keys address lookups in vlan mode
// - entry bits 11:0 hold the vlan identifier, default 0x001
// - untagged or null-tagged packets take their port default identifier
// - packets tagged with a non-null identifier keep the tag identifier in vlan mode
// - vlan lookup first; invalid identifier drops packet without learning
// - destination hit gives ports; miss floods members minus ingress
// - source lookup miss learns filter index and source address
// - control write 0x1402 reads entry 2 into words 5 and 4, or commits them to entry 2 after a fresh load of word 4 or 5
// - static destination result takes precedence over dynamic result
module vlit_top import vlit_pkg::*; #(
  parameter int ENTRIES = VLIT_ENTRIES
) (
  // clock, reset, enable
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic CE_IN,
  // register port
  input wire logic [2:0] REG_ADDR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [15:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  // per-port default identifiers, port 1 in the low bits
  input wire logic [35:0] PORT_DFLT_VID_IN,
  // packet descriptor
  input wire logic PKT_VALID_IN,
  input wire logic [1:0] PKT_PORT_IN,
  input wire logic PKT_TAGGED_IN,
  input wire logic [11:0] PKT_TAG_VID_IN,
  output logic PKT_READY_OUT,
  // address engine
  output logic ADDR_REQ_OUT,
  output logic [3:0] ADDR_FID_OUT,
  input wire logic ADDR_RESP_IN,
  input wire logic DA_STATIC_HIT_IN,
  input wire logic [2:0] DA_STATIC_PORTS_IN,
  input wire logic DA_DYN_HIT_IN,
  input wire logic [2:0] DA_DYN_PORTS_IN,
  input wire logic SA_HIT_IN,
  // decision
  output logic FWD_VALID_OUT,
  output logic [2:0] FWD_PORTS_OUT,
  output logic [11:0] FWD_VID_OUT,
  output logic DROP_OUT,
  output logic LEARN_OUT,
  output logic [3:0] LEARN_FID_OUT,
  // dynamic table read port
  output logic DYN_RD_REQ_OUT,
  output logic [9:0] DYN_RD_IDX_OUT,
  input wire logic DYN_RD_VALID_IN,
  input wire logic [71:0] DYN_RD_DATA_IN
);
  localparam int IW = $clog2(ENTRIES);

  if (ENTRIES < 3 || ENTRIES > 512) begin : g_bad_entries
    $error("ENTRIES must lie between 3 and 512");
  end

  logic [VLIT_EW-1:0] table_reg [ENTRIES];
  logic [15:0] ctrl_reg, switch_global_control_2_reg;
  logic [7:0] w1_reg;
  logic [15:0] w2_reg, w3_reg, w4_reg, w5_reg;
  logic wr_pend_reg, dyn_pend_reg;
  logic trig, rd_sel, idx_ok, vlan_rd, vlan_wr, dyn_trig, dyn_fill;
  logic [1:0] tsel;
  logic [9:0] idx;
  logic [VLIT_EW-1:0] sel_entry;
  logic [ENTRIES-1:0] match;
  vlit_lookup_if lk ();

  // a control write is the trigger; decode its fields
  assign trig = CE_IN && REG_WR_IN && REG_ADDR_IN == VLIT_SEL_CTRL;
  assign tsel = REG_WDATA_IN[VLIT_TSEL_HI:VLIT_TSEL_LO];
  assign rd_sel = REG_WDATA_IN[VLIT_RD_BIT];
  assign idx = REG_WDATA_IN[VLIT_IDX_HI:0];
  assign idx_ok = idx < VLIT_IDX_W'(ENTRIES);
  assign sel_entry = table_reg[idx[IW-1:0]];
  // a read trigger that follows fresh loads of word 4 or 5 commits them instead
  assign vlan_wr = trig && tsel == VLIT_TSEL_VLAN && idx_ok
                   && (!rd_sel || wr_pend_reg);
  assign vlan_rd = trig && tsel == VLIT_TSEL_VLAN && idx_ok
                   && rd_sel && !wr_pend_reg;
  assign dyn_trig = trig && tsel == VLIT_TSEL_DYN && rd_sel;
  assign dyn_fill = CE_IN && dyn_pend_reg && DYN_RD_VALID_IN && !trig;

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      for (int i = 0; i < ENTRIES; i++) begin
        table_reg[i] <= VLIT_ENTRY_RST;
      end
    end else if (vlan_wr) begin
      table_reg[idx[IW-1:0]] <= {w5_reg[VLIT_W5_BITS-1:0], w4_reg};
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      ctrl_reg <= VLIT_REG_RST;
      switch_global_control_2_reg <= VLIT_REG_RST;
    end else if (CE_IN && REG_WR_IN) begin
      if (REG_ADDR_IN == VLIT_SEL_CTRL) ctrl_reg <= REG_WDATA_IN;
      if (REG_ADDR_IN == VLIT_SEL_SWITCH_GLOBAL_CONTROL_2) switch_global_control_2_reg <= REG_WDATA_IN;
    end
  end

  // data words change only on a trigger, a dynamic fill or a host write
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      w1_reg <= VLIT_W1_RST;
      w2_reg <= VLIT_REG_RST;
      w3_reg <= VLIT_REG_RST;
      w4_reg <= VLIT_REG_RST;
      w5_reg <= VLIT_REG_RST;
    end else if (trig) begin
      if (vlan_rd) begin
        w5_reg <= {{(16-VLIT_W5_BITS){1'b0}},
                   sel_entry[VLIT_EW-1:16]};
        w4_reg <= sel_entry[15:0];
      end
      if (dyn_trig) w1_reg <= VLIT_W1_BUSY;
    end else if (dyn_fill) begin
      w1_reg <= DYN_RD_DATA_IN[71:64];
      w3_reg <= DYN_RD_DATA_IN[63:48];
      w2_reg <= DYN_RD_DATA_IN[47:32];
      w5_reg <= DYN_RD_DATA_IN[31:16];
      w4_reg <= DYN_RD_DATA_IN[15:0];
    end else if (CE_IN && REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        VLIT_SEL_W1: w1_reg <= REG_WDATA_IN[7:0];
        VLIT_SEL_W2: w2_reg <= REG_WDATA_IN;
        VLIT_SEL_W3: w3_reg <= REG_WDATA_IN;
        VLIT_SEL_W4: w4_reg <= REG_WDATA_IN;
        VLIT_SEL_W5: w5_reg <= REG_WDATA_IN;
        default: ;
      endcase
    end
  end

  // fresh loads of words 4 or 5 mark a pending vlan entry write
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wr_pend_reg <= 1'b0;
    end else if (trig) begin
      wr_pend_reg <= 1'b0;
    end else if (CE_IN && REG_WR_IN
                 && (REG_ADDR_IN == VLIT_SEL_W4
                     || REG_ADDR_IN == VLIT_SEL_W5)) begin
      wr_pend_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      dyn_pend_reg <= 1'b0;
      DYN_RD_REQ_OUT <= 1'b0;
      DYN_RD_IDX_OUT <= 10'h000;
    end else if (CE_IN) begin
      DYN_RD_REQ_OUT <= dyn_trig;
      if (dyn_trig) begin
        dyn_pend_reg <= 1'b1;
        DYN_RD_IDX_OUT <= idx;
      end else if (DYN_RD_VALID_IN) begin
        dyn_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      REG_RDATA_OUT <= VLIT_REG_RST;
      REG_RVALID_OUT <= 1'b0;
    end else if (CE_IN) begin
      REG_RVALID_OUT <= REG_RD_IN;
      if (REG_RD_IN) begin
        unique case (REG_ADDR_IN)
          VLIT_SEL_CTRL: REG_RDATA_OUT <= ctrl_reg;
          VLIT_SEL_W1: REG_RDATA_OUT <= {8'h00, w1_reg};
          VLIT_SEL_W2: REG_RDATA_OUT <= w2_reg;
          VLIT_SEL_W3: REG_RDATA_OUT <= w3_reg;
          VLIT_SEL_W4: REG_RDATA_OUT <= w4_reg;
          VLIT_SEL_W5: REG_RDATA_OUT <= w5_reg;
          VLIT_SEL_SWITCH_GLOBAL_CONTROL_2: REG_RDATA_OUT <= switch_global_control_2_reg;
          default: REG_RDATA_OUT <= VLIT_REG_RST;
        endcase
      end
    end
  end

  // search every entry for the identifier; only valid entries may match
  for (genvar g = 0; g < ENTRIES; g++) begin : g_match
    assign match[g] = table_reg[g][VLIT_VLD_BIT]
                      && table_reg[g][VLIT_VID_HI:VLIT_VID_LO] == lk.key;
  end

  always_comb begin
    lk.hit = 1'b0;
    lk.members = VLIT_ALL_PORTS;
    lk.filter_index = VLIT_FID_NONE;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (match[i]) begin
        lk.hit = 1'b1;
        lk.members = table_reg[i][VLIT_MEMB_HI:VLIT_MEMB_LO];
        lk.filter_index = table_reg[i][VLIT_FID_HI:VLIT_FID_LO];
      end
    end
  end
  assign lk.vlan_en = switch_global_control_2_reg[VLIT_VLAN_EN_BIT];

  vlit_classifier u_cls (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .ce_in(CE_IN),
    .lk(lk),
    .pkt_valid_in(PKT_VALID_IN),
    .pkt_port_in(PKT_PORT_IN),
    .pkt_tagged_in(PKT_TAGGED_IN),
    .pkt_tag_vid_in(PKT_TAG_VID_IN),
    .dflt_vid_in(PORT_DFLT_VID_IN),
    .pkt_ready_out(PKT_READY_OUT),
    .addr_req_out(ADDR_REQ_OUT),
    .addr_fid_out(ADDR_FID_OUT),
    .addr_resp_in(ADDR_RESP_IN),
    .da_static_hit_in(DA_STATIC_HIT_IN),
    .da_static_ports_in(DA_STATIC_PORTS_IN),
    .da_dyn_hit_in(DA_DYN_HIT_IN),
    .da_dyn_ports_in(DA_DYN_PORTS_IN),
    .sa_hit_in(SA_HIT_IN),
    .fwd_valid_out(FWD_VALID_OUT),
    .fwd_ports_out(FWD_PORTS_OUT),
    .fwd_vid_out(FWD_VID_OUT),
    .drop_out(DROP_OUT),
    .learn_out(LEARN_OUT),
    .learn_fid_out(LEARN_FID_OUT)
  );

  a_dyn_trigger: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    (trig && REG_WDATA_IN == VLIT_CMD_DYN0)
    |=> DYN_RD_REQ_OUT && DYN_RD_IDX_OUT == 10'h000 && w1_reg[7])
    else $error("dynamic entry 0 not fetched");
  a_vlan_read: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    (trig && REG_WDATA_IN == VLIT_CMD_VLAN_RD2 && !wr_pend_reg)
    |=> {w5_reg[VLIT_W5_BITS-1:0], w4_reg} == table_reg[2]
        && w5_reg[15:VLIT_W5_BITS] == '0)
    else $error("vlan entry 2 not presented");
  a_dyn_words: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    dyn_fill |=> w3_reg == $past(DYN_RD_DATA_IN[63:48])
                 && w2_reg == $past(DYN_RD_DATA_IN[47:32])
                 && w5_reg == $past(DYN_RD_DATA_IN[31:16])
                 && w4_reg == $past(DYN_RD_DATA_IN[15:0]))
    else $error("dynamic words misplaced");
  a_data_hold: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    (!trig && !dyn_fill && !(CE_IN && REG_WR_IN))
    |=> $stable(w1_reg) && $stable(w2_reg) && $stable(w3_reg)
        && $stable(w4_reg) && $stable(w5_reg))
    else $error("data words changed without cause");
  a_entry_commit: assert property (
    @(posedge CLK_IN) disable iff (!RST_B_IN)
    vlan_wr |=> table_reg[$past(idx[IW-1:0])] == $past({w5_reg[3:0], w4_reg}))
    else $error("vlan entry not committed");
endmodule

/* File: vlit_pkg.sv */
// constants and types for the vlan lookup and indirect table block
// assumes a single switch clock domain; imported by the top and the classifier
package vlit_pkg;
  // vlan table entry layout
  localparam int VLIT_ENTRIES = 16;
  localparam int VLIT_EW = 20;
  localparam int VLIT_VLD_BIT = 19;
  localparam int VLIT_MEMB_HI = 18;
  localparam int VLIT_MEMB_LO = 16;
  localparam int VLIT_FID_HI = 15;
  localparam int VLIT_FID_LO = 12;
  localparam int VLIT_VID_HI = 11;
  localparam int VLIT_VID_LO = 0;
  localparam int VLIT_VID_W = 12;
  localparam int VLIT_FID_W = 4;
  localparam int VLIT_PORTS_W = 3;
  localparam int VLIT_W5_BITS = 4;
  localparam logic [19:0] VLIT_ENTRY_RST = 20'hF0001;
  localparam logic [11:0] VLIT_NULL_VID = 12'h000;
  localparam logic [2:0] VLIT_ALL_PORTS = 3'h7;
  localparam logic [2:0] VLIT_PORT1_MASK = 3'h1;
  localparam logic [3:0] VLIT_FID_NONE = 4'h0;
  // control register fields
  localparam int VLIT_IDX_HI = 9;
  localparam int VLIT_IDX_W = 10;
  localparam int VLIT_TSEL_HI = 11;
  localparam int VLIT_TSEL_LO = 10;
  localparam int VLIT_RD_BIT = 12;
  localparam logic [1:0] VLIT_TSEL_VLAN = 2'h1;
  localparam logic [1:0] VLIT_TSEL_DYN = 2'h2;
  localparam logic [15:0] VLIT_CMD_DYN0 = 16'h1800;
  localparam logic [15:0] VLIT_CMD_VLAN_RD2 = 16'h1402;
  // global switch control 2
  localparam int VLIT_VLAN_EN_BIT = 15;
  localparam logic [15:0] VLIT_REG_RST = 16'h0000;
  // dynamic table word layout
  localparam int VLIT_DYN_W = 72;
  localparam logic [7:0] VLIT_W1_BUSY = 8'h80;
  localparam logic [7:0] VLIT_W1_RST = 8'h00;
  // register selects on the register port
  localparam logic [2:0] VLIT_SEL_CTRL = 3'h0;
  localparam logic [2:0] VLIT_SEL_W1 = 3'h1;
  localparam logic [2:0] VLIT_SEL_W2 = 3'h2;
  localparam logic [2:0] VLIT_SEL_W3 = 3'h3;
  localparam logic [2:0] VLIT_SEL_W4 = 3'h4;
  localparam logic [2:0] VLIT_SEL_W5 = 3'h5;
  localparam logic [2:0] VLIT_SEL_SWITCH_GLOBAL_CONTROL_2 = 3'h6;
  typedef enum logic [1:0] {VLIT_IDLE, VLIT_LOOKUP, VLIT_WAIT} vlit_state_e;
endpackage

/* File: vlit_lookup_if.sv */
// vlan table search port between the table owner and the classifier
// assumes the search is answered combinationally in the same cycle
`timescale 1ns/1ps
interface vlit_lookup_if;
  logic [11:0] key;
  logic hit;
  logic [2:0] members;
  logic [3:0] filter_index;
  logic vlan_en;
  modport table_side (input key, output hit, output members, output filter_index,
                      output vlan_en);
  modport cls_side (output key, input hit, input members, input filter_index,
                    input vlan_en);
endinterface

/* File: vlit_classifier.sv */
// per-packet vlan assignment, drop, forwarding and learning decision
// assumes address results arrive from an external engine on the same clock
`timescale 1ns/1ps
module vlit_classifier import vlit_pkg::*; (
  // clock and control
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  vlit_lookup_if.cls_side lk,
  // packet descriptor
  input wire logic pkt_valid_in,
  input wire logic [1:0] pkt_port_in,
  input wire logic pkt_tagged_in,
  input wire logic [11:0] pkt_tag_vid_in,
  input wire logic [35:0] dflt_vid_in,
  output logic pkt_ready_out,
  // address engine
  output logic addr_req_out,
  output logic [3:0] addr_fid_out,
  input wire logic addr_resp_in,
  input wire logic da_static_hit_in,
  input wire logic [2:0] da_static_ports_in,
  input wire logic da_dyn_hit_in,
  input wire logic [2:0] da_dyn_ports_in,
  input wire logic sa_hit_in,
  // decision
  output logic fwd_valid_out,
  output logic [2:0] fwd_ports_out,
  output logic [11:0] fwd_vid_out,
  output logic drop_out,
  output logic learn_out,
  output logic [3:0] learn_fid_out
);
  vlit_state_e state_reg, state_next;
  logic [11:0] vid_reg, sel_vid, port_dflt;
  logic [1:0] port_reg;
  logic [2:0] memb_reg, ing_mask;
  logic take, bad_vlan;

  assign take = ce_in && pkt_ready_out && pkt_valid_in;
  assign bad_vlan = lk.vlan_en && !lk.hit;
  assign ing_mask = VLIT_PORT1_MASK << port_reg;
  assign lk.key = vid_reg;

  always_comb begin
    unique case (pkt_port_in)
      2'h0: port_dflt = dflt_vid_in[VLIT_VID_W-1:0];
      2'h1: port_dflt = dflt_vid_in[2*VLIT_VID_W-1:VLIT_VID_W];
      default: port_dflt = dflt_vid_in[3*VLIT_VID_W-1:2*VLIT_VID_W];
    endcase
    // tag wins only when it carries a non-null identifier
    if (lk.vlan_en && pkt_tagged_in && pkt_tag_vid_in != VLIT_NULL_VID) begin
      sel_vid = pkt_tag_vid_in;
    end else begin
      sel_vid = port_dflt;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      VLIT_IDLE: if (take) state_next = VLIT_LOOKUP;
      VLIT_LOOKUP: state_next = bad_vlan ? VLIT_IDLE : VLIT_WAIT;
      VLIT_WAIT: if (addr_resp_in) state_next = VLIT_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= VLIT_IDLE;
      pkt_ready_out <= 1'b1;
    end else if (ce_in) begin
      state_reg <= state_next;
      pkt_ready_out <= (state_next == VLIT_IDLE);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vid_reg <= VLIT_NULL_VID;
      port_reg <= 2'h0;
    end else if (take) begin
      vid_reg <= sel_vid;
      port_reg <= pkt_port_in;
    end
  end

  // vlan table result gates the address lookups
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      drop_out <= 1'b0;
      addr_req_out <= 1'b0;
      addr_fid_out <= VLIT_FID_NONE;
      memb_reg <= VLIT_ALL_PORTS;
    end else if (ce_in) begin
      drop_out <= (state_reg == VLIT_LOOKUP) && bad_vlan;
      addr_req_out <= (state_reg == VLIT_LOOKUP) && !bad_vlan;
      if (state_reg == VLIT_LOOKUP) begin
        addr_fid_out <= lk.vlan_en ? lk.filter_index : VLIT_FID_NONE;
        memb_reg <= lk.vlan_en ? lk.members : VLIT_ALL_PORTS;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fwd_valid_out <= 1'b0;
      fwd_ports_out <= 3'h0;
      fwd_vid_out <= VLIT_NULL_VID;
      learn_out <= 1'b0;
      learn_fid_out <= VLIT_FID_NONE;
    end else if (ce_in) begin
      fwd_valid_out <= 1'b0;
      learn_out <= 1'b0;
      if (state_reg == VLIT_WAIT && addr_resp_in) begin
        fwd_valid_out <= 1'b1;
        fwd_vid_out <= vid_reg;
        if (da_static_hit_in) begin
          fwd_ports_out <= da_static_ports_in;
        end else if (da_dyn_hit_in) begin
          fwd_ports_out <= da_dyn_ports_in;
        end else begin
          fwd_ports_out <= memb_reg & ~ing_mask;
        end
        learn_out <= !sa_hit_in;
        learn_fid_out <= addr_fid_out;
      end
    end
  end

  a_drop_invalid: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (ce_in && state_reg == VLIT_LOOKUP && lk.vlan_en && !lk.hit)
    |=> drop_out && !addr_req_out && !learn_out)
    else $error("bad vlan not dropped");
  a_mode_off_nofid: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (ce_in && state_reg == VLIT_LOOKUP && !lk.vlan_en)
    |=> addr_req_out && addr_fid_out == VLIT_FID_NONE)
    else $error("table used with vlan mode off");
  a_fid_key: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (ce_in && state_reg == VLIT_LOOKUP && lk.vlan_en && lk.hit)
    |=> addr_req_out && addr_fid_out == $past(lk.filter_index))
    else $error("address lookup not keyed on filter index");
  a_static_first: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (ce_in && state_reg == VLIT_WAIT && addr_resp_in && da_static_hit_in)
    |=> fwd_valid_out && fwd_ports_out == $past(da_static_ports_in))
    else $error("static result not preferred");
  a_flood_members: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (ce_in && state_reg == VLIT_WAIT && addr_resp_in && !da_static_hit_in
     && !da_dyn_hit_in)
    |=> fwd_ports_out == $past(memb_reg & ~ing_mask))
    else $error("miss not flooded to members");
  a_learn_miss: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (ce_in && state_reg == VLIT_WAIT && addr_resp_in)
    |=> learn_out == !$past(sa_hit_in)
        && learn_fid_out == $past(addr_fid_out))
    else $error("learning does not follow source miss");
  a_vid_tagged: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (take && lk.vlan_en && pkt_tagged_in && pkt_tag_vid_in != VLIT_NULL_VID)
    |=> vid_reg == $past(pkt_tag_vid_in))
    else $error("tag identifier not used");
  a_vid_default: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (take && lk.vlan_en && (!pkt_tagged_in || pkt_tag_vid_in == VLIT_NULL_VID))
    |=> vid_reg == $past(port_dflt))
    else $error("port default identifier not used");
endmodule

/* File: tb_vlit_top.sv */
// self-checking bench for the vlan lookup and indirect table top
// assumes the design files are compiled first; the bench drives every port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_vlit_top;
  import vlit_pkg::*;
  logic clk = 0, rst_b = 0, wr = 0, rd = 0, pv = 0, ptg = 0, ar = 0, ce = 1;
  logic sth = 0, dyh = 0, sah = 0, dv = 0;
  logic [2:0] addr = 0, stp = 0, dyp = 0, fp;
  logic [15:0] wd = 0, rdat, r;
  logic [1:0] pp = 0;
  logic [11:0] ptv = 0, fvid, vv, ww;
  logic [71:0] dd = 0, t72;
  logic [35:0] dflt = 0;
  logic rv, prdy, areq, fv, drp, lrn, dreq;
  logic [3:0] afid, lfid;
  logic [9:0] didx;
  logic [19:0] e6, e3;
  int n_fail = 0, n_tests = 0, seed = 32'h65d9c1ef, cyc = 0, k;
  always #12.5 clk = ~clk;
  vlit_top uut (.CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdat), .REG_RVALID_OUT(rv), .PORT_DFLT_VID_IN(dflt),
    .PKT_VALID_IN(pv), .PKT_PORT_IN(pp), .PKT_TAGGED_IN(ptg),
    .PKT_TAG_VID_IN(ptv), .PKT_READY_OUT(prdy), .ADDR_REQ_OUT(areq),
    .ADDR_FID_OUT(afid), .ADDR_RESP_IN(ar), .DA_STATIC_HIT_IN(sth),
    .DA_STATIC_PORTS_IN(stp), .DA_DYN_HIT_IN(dyh), .DA_DYN_PORTS_IN(dyp),
    .SA_HIT_IN(sah), .FWD_VALID_OUT(fv), .FWD_PORTS_OUT(fp),
    .FWD_VID_OUT(fvid), .DROP_OUT(drp), .LEARN_OUT(lrn),
    .LEARN_FID_OUT(lfid), .DYN_RD_REQ_OUT(dreq), .DYN_RD_IDX_OUT(didx),
    .DYN_RD_VALID_IN(dv), .DYN_RD_DATA_IN(dd));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test;
    end
  end
  function automatic logic [19:0] ent_of(logic [11:0] v);
    if (v == e6[11:0]) return e6;
    if (v == 12'h001) return VLIT_ENTRY_RST;
    return 20'h00000;
  endfunction
  function automatic logic [2:0] exp_ports(logic sh, logic [2:0] sp,
      logic dh, logic [2:0] dp, logic [2:0] m, logic [1:0] p);
    if (sh) return sp;
    if (dh) return dp;
    return m & ~(3'h1 << p);
  endfunction
  task automatic wreg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, rv)
    d = rdat;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [15:0] e,
      input string nm);
    logic [15:0] d;
    rreg(a, d);
    `CHK(nm, e, d)
  endtask
  task automatic vrd(input logic [3:0] i, input logic [19:0] e);
    wreg(VLIT_SEL_CTRL, 16'h1400 | 16'(i));
    rchk(VLIT_SEL_W5, {12'h000, e[19:16]}, "entry hi");
    rchk(VLIT_SEL_W4, e[15:0], "entry lo");
  endtask
  task automatic pkt(input logic on, input logic [1:0] p, input logic t,
      input logic [11:0] tv);
    logic [11:0] ev;
    logic [19:0] en;
    logic s1, s2, s3;
    logic [2:0] q1, q2, ep;
    ev = (!t || tv == VLIT_NULL_VID) ? dflt[p * 12 +: 12] : tv;
    en = on ? ent_of(ev) : {1'b1, VLIT_ALL_PORTS, VLIT_FID_NONE, ev};
    {s1, s2, s3, q1, q2} = 9'($random(seed));
    ep = exp_ports(s1, q1, s2, q2, en[18:16], p);
    @(posedge clk);
    pv <= 1'b1;
    pp <= p;
    ptg <= t;
    ptv <= tv;
    @(posedge clk);
    pv <= 1'b0;
    #1;
    `CHK("busy", 1'b0, prdy)
    for (k = 0; k < 6 && areq !== 1'b1 && drp !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    `CHK("drop", ~en[19], drp)
    `CHK("addr req", en[19], areq)
    if (en[19]) begin
      `CHK("addr fid", en[15:12], afid)
      @(posedge clk);
      ar <= 1'b1;
      sth <= s1;
      stp <= q1;
      dyh <= s2;
      dyp <= q2;
      sah <= s3;
      @(posedge clk);
      ar <= 1'b0;
      #1;
      `CHK("fwd valid", 1'b1, fv)
      `CHK("ports", ep, fp)
      `CHK("learn", ~s3, lrn)
      if (!s3) `CHK("learn fid", en[15:12], lfid)
      if (on) `CHK("vid", ev, fvid)
    end
    `CHK("ready", 1'b1, prdy)
  endtask
  initial begin
    vv = {4'h5, 8'($random(seed))};
    ww = {4'hA, 8'($random(seed))};
    e6 = {1'b1, 3'($random(seed)), 4'($random(seed)), vv};
    e3 = {1'b0, 3'h7, 4'h3, ww};
    dflt <= {ww, 12'h001, vv};
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    wreg(VLIT_SEL_CTRL, VLIT_CMD_VLAN_RD2);
    rchk(VLIT_SEL_W5, 16'h000F, "w5 reset");
    rchk(VLIT_SEL_W4, 16'h0001, "w4 reset");
    wreg(3'h7, 16'hFFFF);
    rchk(3'h7, 16'h0000, "unmapped");
    wreg(VLIT_SEL_W5, {12'h000, e6[19:16]});
    wreg(VLIT_SEL_W4, e6[15:0]);
    wreg(VLIT_SEL_CTRL, 16'h1406);
    wreg(VLIT_SEL_W5, {12'h000, e3[19:16]});
    wreg(VLIT_SEL_W4, e3[15:0]);
    wreg(VLIT_SEL_CTRL, 16'h0403);
    vrd(4'h6, e6);
    vrd(4'h3, e3);
    // an index past the table is refused, the words keep entry 3
    wreg(VLIT_SEL_CTRL, 16'h1410);
    rchk(VLIT_SEL_W4, e3[15:0], "refused index");
    rchk(VLIT_SEL_CTRL, 16'h1410, "control");
    $display("test vlan table done");
    wreg(VLIT_SEL_CTRL, VLIT_CMD_DYN0);
    #1;
    for (k = 0; k < 4 && dreq !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    `CHK("dyn req", 1'b1, dreq)
    `CHK("dyn idx", 10'h000, didx)
    rchk(VLIT_SEL_W1, {8'h00, VLIT_W1_BUSY}, "w1 busy");
    t72 = {8'($random(seed)) & 8'h7F, 32'($random(seed)), 32'($random(seed))};
    @(posedge clk);
    dv <= 1'b1;
    dd <= t72;
    @(posedge clk);
    dv <= 1'b0;
    for (k = 0; k < 4; k++) begin
      rreg(VLIT_SEL_W1, r);
      if (r[7] === 1'b0) break;
    end
    `CHK("w1", {8'h00, t72[71:64]}, r)
    rchk(VLIT_SEL_W3, t72[63:48], "w3");
    rchk(VLIT_SEL_W2, t72[47:32], "w2");
    rchk(VLIT_SEL_W5, t72[31:16], "w5");
    rchk(VLIT_SEL_W4, t72[15:0], "w4");
    $display("test dynamic read done");
    pkt(1'b0, 2'h1, 1'b1, ww);
    wreg(VLIT_SEL_SWITCH_GLOBAL_CONTROL_2, 16'h8000);
    rchk(VLIT_SEL_SWITCH_GLOBAL_CONTROL_2, 16'h8000, "control 2");
    pkt(1'b1, 2'h2, 1'b0, 12'h000);
    pkt(1'b1, 2'h0, 1'b1, VLIT_NULL_VID);
    pkt(1'b1, 2'h1, 1'b1, ww);
    repeat (24) begin
      case ($unsigned($random(seed)) % 5)
        0: t72[11:0] = 12'h000;
        1: t72[11:0] = vv;
        2: t72[11:0] = 12'h001;
        3: t72[11:0] = ww;
        default: t72[11:0] = 12'($random(seed));
      endcase
      pkt(1'b1, 2'($unsigned($random(seed)) % 3), 1'($random(seed)),
          t72[11:0]);
    end
    // a host write while the clock enable is low must be ignored
    @(posedge clk);
    ce <= 1'b0;
    wreg(VLIT_SEL_W3, ~dd[63:48]);
    ce <= 1'b1;
    rchk(VLIT_SEL_W3, dd[63:48], "w3 hold");
    $display("test packets done");
    finish_test;
  end
endmodule
